// ---- rtl/gpio_ports_with_pin_remap.sv ----
// Purpose: two-bank general-purpose port with pin ownership resolution
// Assumes: all inputs synchronous to clk_i; peripherals present one output per pin
// Notes: pad drive is split into out/oe; pulls and analog enables go to the pad cell
// Operation
// - one output function drives a pin
// - one remappable output may reach several pins
// - dedicated output beats remappable output
// - remappable inputs allowed beside dedicated functions
// - analog pin disables digital input, keeps output
// - many remappable inputs observe one pin
// - direction gates only the general output buffer
// - direction never gates input; software sets input
// - analog pins reset analog, input buffer off
// - only analog select gates digital input
// - bank A five bits, documented reset values
// - bank B sixteen bits, documented reset values
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "gpio_consts.svh"

module gpio_ports_with_pin_remap #(
  parameter int A_W = `A_W,
  parameter int B_W = `B_W
)(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DATA_W-1:0] rdata_o,
  input wire logic [A_W-1:0] pad_a_i,
  output logic [A_W-1:0] pad_a_o,
  output logic [A_W-1:0] pad_a_oe_o,
  output logic [A_W-1:0] pad_a_pu_o,
  output logic [A_W-1:0] pad_a_pd_o,
  output logic [A_W-1:0] pad_a_analog_o,
  output logic [A_W-1:0] a_digital_in_o,
  input wire logic [A_W-1:0] ded_a_oe_i,
  input wire logic [A_W-1:0] ded_a_out_i,
  input wire logic [A_W-1:0] remap_a_oe_i,
  input wire logic [A_W-1:0] remap_a_out_i,
  input wire logic [B_W-1:0] pad_b_i,
  output logic [B_W-1:0] pad_b_o,
  output logic [B_W-1:0] pad_b_oe_o,
  output logic [B_W-1:0] pad_b_pu_o,
  output logic [B_W-1:0] pad_b_pd_o,
  output logic [B_W-1:0] pad_b_analog_o,
  output logic [B_W-1:0] b_digital_in_o,
  input wire logic [B_W-1:0] ded_b_oe_i,
  input wire logic [B_W-1:0] ded_b_out_i,
  input wire logic [B_W-1:0] remap_b_oe_i,
  input wire logic [B_W-1:0] remap_b_out_i,
  output logic [A_W-1:0] a_change_o,
  output logic [B_W-1:0] b_change_o
);

  // ==========================================================
  // register state
  logic [A_W-1:0] a_dir_r, a_dir_nxt, a_lat_r, a_lat_nxt, a_odc_r, a_odc_nxt;
  logic [A_W-1:0] a_cne_r, a_cne_nxt, a_pu_r, a_pu_nxt, a_pd_r, a_pd_nxt;
  logic [A_W-1:0] a_ans_r, a_ans_nxt, a_smp_r, a_smp_nxt;
  logic [B_W-1:0] b_dir_r, b_dir_nxt, b_lat_r, b_lat_nxt, b_odc_r, b_odc_nxt;
  logic [B_W-1:0] b_cne_r, b_cne_nxt, b_pu_r, b_pu_nxt, b_pd_r, b_pd_nxt;
  logic [B_W-1:0] b_ans_r, b_ans_nxt, b_smp_r, b_smp_nxt;
  logic [`DATA_W-1:0] rdata_nxt;

  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // widen a bank value to the data bus, upper bits read as zero
  function automatic logic [`DATA_W-1:0] zext_a(input logic [A_W-1:0] v);
    zext_a = '0;
    zext_a[A_W-1:0] = v;
  endfunction

  function automatic logic [`DATA_W-1:0] zext_b(input logic [B_W-1:0] v);
    zext_b = '0;
    zext_b[B_W-1:0] = v;
  endfunction

  // single winner per pin: dedicated, then remap, then the latch
  function automatic gpio_pkg::pin_owner_type pick_owner(input logic ded_oe, input logic rem_oe);
    if (ded_oe)
      pick_owner = gpio_pkg::OWNER_DEDICATED;
    else if (rem_oe)
      pick_owner = gpio_pkg::OWNER_REMAP;
    else
      pick_owner = gpio_pkg::OWNER_GPIO;
  endfunction

  // value of the winning driver
  function automatic logic pick_out(input gpio_pkg::pin_owner_type own, input logic ded,
    input logic rem, input logic lat);
    case (own)
      gpio_pkg::OWNER_DEDICATED: pick_out = ded;
      gpio_pkg::OWNER_REMAP: pick_out = rem;
      default: pick_out = lat;
    endcase
  endfunction

  // peripheral outputs override direction; open drain releases a high level
  function automatic logic pick_oe(input gpio_pkg::pin_owner_type own, input logic dir,
    input logic odc, input logic val);
    pick_oe = (own != gpio_pkg::OWNER_GPIO) || !dir;
    if (odc && val)
      pick_oe = 1'b0;
  endfunction

  // change flag: enabled, digital, and level moved since the last sample
  function automatic logic pick_chg(input logic cne, input logic ans, input logic now,
    input logic old);
    pick_chg = cne && !ans && (now != old);
  endfunction

  // ==========================================================
  // bank A software writes
  always_comb
  begin
    a_dir_nxt = a_dir_r;
    a_lat_nxt = a_lat_r;
    a_odc_nxt = a_odc_r;
    a_cne_nxt = a_cne_r;
    a_pu_nxt = a_pu_r;
    a_pd_nxt = a_pd_r;
    a_ans_nxt = a_ans_r;
    a_smp_nxt = pad_a_i;
    if (wr_i)
    begin
      if (hit(addr_i, `OFF_A_DIR))
        a_dir_nxt = wdata_i[A_W-1:0];
      // writing the pin level lands in the output latch
      if (hit(addr_i, `OFF_A_PIN) || hit(addr_i, `OFF_A_LAT))
        a_lat_nxt = wdata_i[A_W-1:0];
      if (hit(addr_i, `OFF_A_ODC))
        a_odc_nxt = wdata_i[A_W-1:0];
      if (hit(addr_i, `OFF_A_CNE))
        a_cne_nxt = wdata_i[A_W-1:0];
      if (hit(addr_i, `OFF_A_PU))
        a_pu_nxt = wdata_i[A_W-1:0];
      if (hit(addr_i, `OFF_A_PD))
        a_pd_nxt = wdata_i[A_W-1:0];
      if (hit(addr_i, `OFF_A_ANS))
        a_ans_nxt = wdata_i[A_W-1:0] & `MASK_A_ANS;
    end
  end

  // ==========================================================
  // bank B software writes
  always_comb
  begin
    b_dir_nxt = b_dir_r;
    b_lat_nxt = b_lat_r;
    b_odc_nxt = b_odc_r;
    b_cne_nxt = b_cne_r;
    b_pu_nxt = b_pu_r;
    b_pd_nxt = b_pd_r;
    b_ans_nxt = b_ans_r;
    b_smp_nxt = pad_b_i;
    if (wr_i)
    begin
      if (hit(addr_i, `OFF_B_DIR))
        b_dir_nxt = wdata_i[B_W-1:0];
      // writing the pin level lands in the output latch
      if (hit(addr_i, `OFF_B_PIN) || hit(addr_i, `OFF_B_LAT))
        b_lat_nxt = wdata_i[B_W-1:0];
      if (hit(addr_i, `OFF_B_ODC))
        b_odc_nxt = wdata_i[B_W-1:0];
      if (hit(addr_i, `OFF_B_CNE))
        b_cne_nxt = wdata_i[B_W-1:0];
      if (hit(addr_i, `OFF_B_PU))
        b_pu_nxt = wdata_i[B_W-1:0];
      if (hit(addr_i, `OFF_B_PD))
        b_pd_nxt = wdata_i[B_W-1:0];
      if (hit(addr_i, `OFF_B_ANS))
        b_ans_nxt = wdata_i[B_W-1:0] & `MASK_B_ANS;
    end
  end

  // ==========================================================
  // read mux, data one cycle after the strobe
  always_comb
  begin
    rdata_nxt = '0;
    if (rd_i)
    begin
      case (addr_i)
        `OFF_A_DIR: rdata_nxt = zext_a(a_dir_r);
        `OFF_A_PIN: rdata_nxt = zext_a(a_smp_r);
        `OFF_A_LAT: rdata_nxt = zext_a(a_lat_r);
        `OFF_A_ODC: rdata_nxt = zext_a(a_odc_r);
        `OFF_A_CNE: rdata_nxt = zext_a(a_cne_r);
        `OFF_A_PU: rdata_nxt = zext_a(a_pu_r);
        `OFF_A_PD: rdata_nxt = zext_a(a_pd_r);
        `OFF_A_ANS: rdata_nxt = zext_a(a_ans_r);
        `OFF_B_DIR: rdata_nxt = zext_b(b_dir_r);
        `OFF_B_PIN: rdata_nxt = zext_b(b_smp_r);
        `OFF_B_LAT: rdata_nxt = zext_b(b_lat_r);
        `OFF_B_ODC: rdata_nxt = zext_b(b_odc_r);
        `OFF_B_CNE: rdata_nxt = zext_b(b_cne_r);
        `OFF_B_PU: rdata_nxt = zext_b(b_pu_r);
        `OFF_B_PD: rdata_nxt = zext_b(b_pd_r);
        `OFF_B_ANS: rdata_nxt = zext_b(b_ans_r);
        default: rdata_nxt = '0;
      endcase
    end
  end

  // ==========================================================
  // pin ownership and pad drive
  logic [A_W-1:0] a_out_nxt, a_oe_nxt, a_din_nxt, a_chg_nxt;
  logic [A_W-1:0] a_pu_out_nxt, a_pd_out_nxt, a_ana_out_nxt;
  logic [B_W-1:0] b_out_nxt, b_oe_nxt, b_din_nxt, b_chg_nxt;
  logic [B_W-1:0] b_pu_out_nxt, b_pd_out_nxt, b_ana_out_nxt;
  gpio_pkg::pin_owner_type a_own [A_W];
  gpio_pkg::pin_owner_type b_own [B_W];

  always_comb
  begin
    for (int i = 0; i < A_W; i++)
    begin
      a_own[i] = pick_owner(ded_a_oe_i[i], remap_a_oe_i[i]);
      a_out_nxt[i] = pick_out(a_own[i], ded_a_out_i[i], remap_a_out_i[i], a_lat_r[i]);
      a_oe_nxt[i] = pick_oe(a_own[i], a_dir_r[i], a_odc_r[i], a_out_nxt[i]);
      // input buffer follows analog select only, shared by all observers
      a_din_nxt[i] = pad_a_i[i] & !a_ans_r[i];
      a_chg_nxt[i] = pick_chg(a_cne_r[i], a_ans_r[i], pad_a_i[i], a_smp_r[i]);
    end
    a_pu_out_nxt = a_pu_r;
    a_pd_out_nxt = a_pd_r;
    a_ana_out_nxt = a_ans_r;
  end

  always_comb
  begin
    for (int j = 0; j < B_W; j++)
    begin
      b_own[j] = pick_owner(ded_b_oe_i[j], remap_b_oe_i[j]);
      b_out_nxt[j] = pick_out(b_own[j], ded_b_out_i[j], remap_b_out_i[j], b_lat_r[j]);
      b_oe_nxt[j] = pick_oe(b_own[j], b_dir_r[j], b_odc_r[j], b_out_nxt[j]);
      // input buffer follows analog select only, shared by all observers
      b_din_nxt[j] = pad_b_i[j] & !b_ans_r[j];
      b_chg_nxt[j] = pick_chg(b_cne_r[j], b_ans_r[j], pad_b_i[j], b_smp_r[j]);
    end
    b_pu_out_nxt = b_pu_r;
    b_pd_out_nxt = b_pd_r;
    b_ana_out_nxt = b_ans_r;
  end

  // ==========================================================
  // bank A registers
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      a_dir_r <= `RST_A_DIR;
      a_lat_r <= `RST_ZERO_A;
      a_odc_r <= `RST_ZERO_A;
      a_cne_r <= `RST_ZERO_A;
      a_pu_r <= `RST_ZERO_A;
      a_pd_r <= `RST_ZERO_A;
      a_ans_r <= `RST_A_ANS;
      a_smp_r <= `RST_ZERO_A;
    end
    else
    begin
      a_dir_r <= a_dir_nxt;
      a_lat_r <= a_lat_nxt;
      a_odc_r <= a_odc_nxt;
      a_cne_r <= a_cne_nxt;
      a_pu_r <= a_pu_nxt;
      a_pd_r <= a_pd_nxt;
      a_ans_r <= a_ans_nxt;
      a_smp_r <= a_smp_nxt;
    end
  end

  // ==========================================================
  // bank B registers; the latch reset is a fixed zero, not left unknown
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      b_dir_r <= `RST_B_DIR;
      b_lat_r <= `RST_B_LAT;
      b_odc_r <= `RST_ZERO_B;
      b_cne_r <= `RST_ZERO_B;
      b_pu_r <= `RST_ZERO_B;
      b_pd_r <= `RST_ZERO_B;
      b_ans_r <= `RST_B_ANS;
      b_smp_r <= `RST_ZERO_B;
    end
    else
    begin
      b_dir_r <= b_dir_nxt;
      b_lat_r <= b_lat_nxt;
      b_odc_r <= b_odc_nxt;
      b_cne_r <= b_cne_nxt;
      b_pu_r <= b_pu_nxt;
      b_pd_r <= b_pd_nxt;
      b_ans_r <= b_ans_nxt;
      b_smp_r <= b_smp_nxt;
    end
  end

  // ==========================================================
  // read data register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // bank A pad outputs
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pad_a_o <= `RST_ZERO_A;
      pad_a_oe_o <= `RST_ZERO_A;
      pad_a_pu_o <= `RST_ZERO_A;
      pad_a_pd_o <= `RST_ZERO_A;
      pad_a_analog_o <= `RST_A_ANS;
      a_digital_in_o <= `RST_ZERO_A;
      a_change_o <= `RST_ZERO_A;
    end
    else
    begin
      pad_a_o <= a_out_nxt;
      pad_a_oe_o <= a_oe_nxt;
      pad_a_pu_o <= a_pu_out_nxt;
      pad_a_pd_o <= a_pd_out_nxt;
      pad_a_analog_o <= a_ana_out_nxt;
      a_digital_in_o <= a_din_nxt;
      a_change_o <= a_chg_nxt;
    end
  end

  // ==========================================================
  // bank B pad outputs
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pad_b_o <= `RST_ZERO_B;
      pad_b_oe_o <= `RST_ZERO_B;
      pad_b_pu_o <= `RST_ZERO_B;
      pad_b_pd_o <= `RST_ZERO_B;
      pad_b_analog_o <= `RST_B_ANS;
      b_digital_in_o <= `RST_ZERO_B;
      b_change_o <= `RST_ZERO_B;
    end
    else
    begin
      pad_b_o <= b_out_nxt;
      pad_b_oe_o <= b_oe_nxt;
      pad_b_pu_o <= b_pu_out_nxt;
      pad_b_pd_o <= b_pd_out_nxt;
      pad_b_analog_o <= b_ana_out_nxt;
      b_digital_in_o <= b_din_nxt;
      b_change_o <= b_chg_nxt;
    end
  end

endmodule

// ---- rtl/gpio_consts.svh ----
// Purpose: register offsets, reset values and widths of the two-bank port block
// Assumes: byte addresses as printed, one 16-bit register per even address
// Notes: included by the port module only, not by the package
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

`define ADDR_W 16
`define DATA_W 16
`define A_W 5
`define B_W 16

`define OFF_A_DIR 16'h0E00
`define OFF_A_PIN 16'h0E02
`define OFF_A_LAT 16'h0E04
`define OFF_A_ODC 16'h0E06
`define OFF_A_CNE 16'h0E08
`define OFF_A_PU 16'h0E0A
`define OFF_A_PD 16'h0E0C
`define OFF_A_ANS 16'h0E0E
`define OFF_B_DIR 16'h0E10
`define OFF_B_PIN 16'h0E12
`define OFF_B_LAT 16'h0E14
`define OFF_B_ODC 16'h0E16
`define OFF_B_CNE 16'h0E18
`define OFF_B_PU 16'h0E1A
`define OFF_B_PD 16'h0E1C
`define OFF_B_ANS 16'h0E1E

`define RST_A_DIR 5'h1F
`define RST_A_ANS 5'h07
`define MASK_A_ANS 5'h07
`define RST_ZERO_A 5'h00
`define RST_B_DIR 16'hFFFF
`define RST_B_ANS 16'h06FF
`define MASK_B_ANS 16'h06FF
`define RST_ZERO_B 16'h0000
`define RST_B_LAT 16'h0000

`endif

// ---- rtl/gpio_pkg.sv ----
// Purpose: types shared by the port block
// Assumes: nothing
// Notes: constants live in gpio_consts.svh
package gpio_pkg;
  typedef enum logic [1:0]
  {
    OWNER_GPIO = 2'h0,
    OWNER_REMAP = 2'h1,
    OWNER_DEDICATED = 2'h3
  } pin_owner_type;
endpackage

// ---- tb/gpio_ports_with_pin_remap_asserts.sv ----
// Purpose: port-level checks of the two-bank port block
// Assumes: bound to every instance of the port block
// Notes: pad outputs lag their cause by one edge
`timescale 1ns/1ps
module gpio_asserts #(
  parameter int A_W = 5,
  parameter int B_W = 16
)(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [A_W-1:0] pad_a_analog_o,
  input wire logic [B_W-1:0] pad_b_o,
  input wire logic [B_W-1:0] pad_b_oe_o,
  input wire logic [B_W-1:0] pad_b_analog_o,
  input wire logic [B_W-1:0] b_digital_in_o,
  input wire logic [B_W-1:0] ded_b_oe_i,
  input wire logic [B_W-1:0] ded_b_out_i,
  input wire logic [B_W-1:0] remap_b_oe_i,
  input wire logic [B_W-1:0] remap_b_out_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic live_r;
  logic [B_W-1:0] ded_lo_r, ded_hi_r, rem_lo_r;
  // ==========
  // helpers: causes one edge back
  always_ff @(posedge clk_i)
  begin
    live_r <= resetn_i;
    ded_lo_r <= ded_b_oe_i & ~ded_b_out_i;
    ded_hi_r <= ded_b_oe_i & ded_b_out_i;
    rem_lo_r <= remap_b_oe_i & ~ded_b_oe_i & ~remap_b_out_i;
  end
  sequence s_wr_cne;
    wr_i && addr_i == 16'h0E18;
  endsequence
  sequence s_rd_cne;
    rd_i && addr_i == 16'h0E18;
  endsequence
  a_idle_zero: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside its slot");
  a_read_back: assert property (s_wr_cne ##2 s_rd_cne |=> rdata_o == $past(wdata_i, 3))
    else $error("register read back wrong");
  a_unmapped_zero: assert property (rd_i && addr_i[15:5] != 11'h070 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_ded_drives_low: assert property (live_r |-> (pad_b_oe_o & ~pad_b_o & ded_lo_r) == ded_lo_r)
    else $error("dedicated low not driven");
  a_ded_beats_remap: assert property (live_r |-> (pad_b_oe_o & ~pad_b_o & ded_hi_r) == '0)
    else $error("dedicated high pin pulled low");
  a_remap_drives_low: assert property (live_r |-> (pad_b_oe_o & ~pad_b_o & rem_lo_r) == rem_lo_r)
    else $error("remapped low not driven");
  a_analog_in_off: assert property ((b_digital_in_o & pad_b_analog_o) == '0)
    else $error("digital input live on analog pin");
  a_analog_mask: assert property (pad_b_analog_o[15:11] == 5'h00 && !pad_b_analog_o[8]
    && pad_a_analog_o[A_W-1:3] == '0)
    else $error("analog enable on pin without analog");
endmodule

bind gpio_ports_with_pin_remap gpio_asserts #(.A_W(A_W), .B_W(B_W)) u_gpio_asserts (.*);

// ---- tb/pad_model.sv ----
// Purpose: outside circuitry on the bank B pins
// Assumes: block driver wins over the outside source
// Notes: a pin with no driver and no pull wanders
`timescale 1ns/1ps
module pad_model #(
  parameter int W = 16
)(
  input wire logic clk_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pu_i,
  input wire logic [W-1:0] pd_i,
  input wire logic [W-1:0] ext_i,
  input wire logic [W-1:0] ext_oe_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] float_r = '0;
  // ==========
  // pin resolution
  always_ff @(posedge clk_i)
  begin
    float_r <= ~float_r;
  end
  assign level_o = (oe_i & out_i) | (~oe_i & ext_oe_i & ext_i)
    | (~oe_i & ~ext_oe_i & (pu_i | (~pd_i & float_r)));
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the two-bank port block
// Assumes: bank A peripheral outputs unused
// Notes: offsets walk 0E00..0E1E in steps of two
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [4:0] pad_a_i = 5'h00;
  logic [15:0] ded_b_oe_i = 16'h0000;
  logic [15:0] ded_b_out_i = 16'h0000;
  logic [15:0] remap_b_oe_i = 16'h0000;
  logic [15:0] remap_b_out_i = 16'h0000;
  logic [15:0] ext_b = 16'h0000;
  logic [15:0] ext_oe = 16'h0000;
  logic [15:0] rdata_o, pad_b_i, pad_b_o, pad_b_oe_o, pad_b_pu_o, pad_b_pd_o;
  logic [15:0] pad_b_analog_o, b_digital_in_o, b_change_o, got, seen;
  logic [4:0] pad_a_o, pad_a_oe_o, pad_a_pu_o, pad_a_pd_o, pad_a_analog_o;
  logic [4:0] a_digital_in_o, a_change_o;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  gpio_ports_with_pin_remap u_gpio_ports_with_pin_remap (
    .*,
    .ded_a_oe_i(5'h00),
    .ded_a_out_i(5'h00),
    .remap_a_oe_i(5'h00),
    .remap_a_out_i(5'h00)
  );
  pad_model u_pad_model (
    .clk_i(clk_i),
    .out_i(pad_b_o),
    .oe_i(pad_b_oe_o),
    .pu_i(pad_b_pu_o),
    .pd_i(pad_b_pd_o),
    .ext_i(ext_b),
    .ext_oe_i(ext_oe),
    .level_o(pad_b_i)
  );
  // ==========
  // bus and compare tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    got = rdata_o;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 16; i++)
    begin
      if (i != 9)
      begin
        rd(16'h0E00 + 16'(2 * i));
        chk(got, i == 0 ? 16'h001F : i == 7 ? 16'h0007 : i == 8 ? 16'hFFFF
          : i == 15 ? 16'h06FF : 16'h0000, "reset value");
      end
    end
    rd(16'h0E20);
    chk(got, 16'h0000, "unmapped read");
    rd(16'h0D00);
    chk(got, 16'h0000, "foreign read");
    chk(pad_b_analog_o, 16'h06FF, "analog after reset");
    chk(pad_a_analog_o, 16'h0007, "bank A analog after reset");
    chk(a_digital_in_o, 16'h0000, "bank A input off");
  endtask
  task automatic t_bank_a;
    wr(16'h0E04, 16'h0015);
    settle;
    chk(pad_a_oe_o, 16'h001F, "bank A enables");
    chk(pad_a_o, 16'h0015, "bank A values");
    wr(16'h0E06, 16'h001F);
    settle;
    chk(pad_a_oe_o, 16'h000A, "bank A open drain");
    @(posedge clk_i);
    pad_a_i <= 5'h0A;
    wr(16'h0E0A, 16'h001F);
    wr(16'h0E0C, 16'h0003);
    wr(16'h0E08, 16'h001F);
    settle;
    chk(a_digital_in_o, 16'h000A, "bank A inputs");
    chk(pad_a_pu_o, 16'h001F, "bank A pull ups");
    chk(pad_a_pd_o, 16'h0003, "bank A pull downs");
    seen = 16'h0000;
    @(posedge clk_i);
    pad_a_i <= 5'h0B;
    repeat (4)
    begin
      @(negedge clk_i);
      seen = seen | a_change_o;
    end
    chk(seen, 16'h0001, "bank A change");
  endtask
  task automatic t_rw;
    for (int i = 0; i < 16; i++)
    begin
      wr(16'h0E00 + 16'(2 * i), 16'hFFFF);
      if (i % 8 != 1)
      begin
        rd(16'h0E00 + 16'(2 * i));
        chk(got, i == 7 ? 16'h0007 : i == 15 ? 16'h06FF : i < 8 ? 16'h001F
          : 16'hFFFF, "write mask");
      end
      wr(16'h0E00 + 16'(2 * i), 16'h0000);
    end
  endtask
  task automatic t_priority;
    wr(16'h0E10, 16'hF0FF);
    wr(16'h0E14, 16'h0A00);
    @(posedge clk_i);
    ded_b_oe_i <= 16'h000F;
    ded_b_out_i <= 16'h0005;
    remap_b_oe_i <= 16'h00FF;
    remap_b_out_i <= 16'h00CA;
    settle;
    chk(pad_b_oe_o, 16'h0FFF, "owner enables");
    chk(pad_b_o & 16'h0FFF, 16'h0AC5, "owner values");
    wr(16'h0E16, 16'hFFFF);
    settle;
    chk(pad_b_oe_o, 16'h053A, "open drain");
    wr(16'h0E16, 16'h0000);
    @(posedge clk_i);
    remap_b_oe_i <= 16'h0000;
  endtask
  task automatic t_inputs;
    seen = 16'h0000;
    wr(16'h0E10, 16'hFFFF);
    @(posedge clk_i);
    ext_b <= 16'h5A5A;
    ext_oe <= 16'hFFFE;
    ded_b_oe_i <= 16'h0001;
    ded_b_out_i <= 16'h0001;
    settle;
    chk(b_digital_in_o, 16'h5A5B, "inputs beside outputs");
    rd(16'h0E12);
    chk(got, 16'h5A5B, "pin level read");
    wr(16'h0E1E, 16'h06FF);
    settle;
    chk(b_digital_in_o, 16'h5800, "analog blocks input");
    chk(pad_b_oe_o, 16'h0001, "output kept on analog pin");
    wr(16'h0E1E, 16'h0002);
    wr(16'h0E18, 16'hFFFF);
    settle;
    @(posedge clk_i);
    ext_b <= 16'h5858;
    repeat (4)
    begin
      @(negedge clk_i);
      seen = seen | b_change_o;
    end
    chk(seen, 16'h0200, "change notify");
    @(posedge clk_i);
    ext_oe <= 16'h0000;
    wr(16'h0E1A, 16'hFFFF);
    settle;
    chk(b_digital_in_o, 16'hFFFD, "pull ups");
    chk(pad_b_pu_o, 16'hFFFF, "pull up enables");
  endtask
  task automatic t_rereset;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(16'h0E0E);
    chk(got, 16'h0007, "analog after second reset");
    chk(pad_b_analog_o, 16'h06FF, "bank B analog again");
    chk(a_digital_in_o, 16'h0008, "bank A input gated again");
  endtask
  // ==========
  // clock, watchdog, sequence
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_rw;
    t_bank_a;
    t_priority;
    t_inputs;
    t_rereset;
    wrap_up;
  end
endmodule
